// ### rtl/rdr_pkg.sv
// Constants, types and carriers of the reader trigger sequencer
package rdr_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int TIME_BASE_MS = 100;
    localparam int TB_CYC = TIME_BASE_MS * (CLK_HZ / 1000);
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_WDATA = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_SAVED = 8'h0c;
    localparam logic [3:0] OP_SET_TOR = 4'h0;
    localparam logic [3:0] OP_SET_MODE = 4'h1;
    localparam logic [3:0] OP_SHOW = 4'h2;
    localparam logic [3:0] OP_PERSIST = 4'h3;
    localparam logic [3:0] OP_GET_TAG = 4'h4;
    localparam logic [3:0] OP_SEL_READ = 4'h5;
    localparam logic [3:0] OP_WRITE = 4'h6;
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_TRIG = 2'h2;
    localparam logic [1:0] MODE_RST = 2'h2;
    localparam logic [7:0] TOR_RST = 8'h0a;
    localparam logic [7:0] TOR_TOP = 8'hff;
    localparam logic [8:0] TOR_FULL = 9'h100;
    localparam logic [7:0] BLK1K_LO = 8'h03;
    localparam logic [7:0] BLK1K_HI = 8'h21;
    localparam logic [7:0] BLK2K_LO = 8'h10;
    localparam logic [7:0] BLK2K_HI = 8'h3f;
    localparam logic [7:0] SER_BLK_1K = 8'h20;
    localparam logic [7:0] SER_BLK_2K = 8'h01;
    localparam logic [3:0] RO_CHARS = 4'ha;
    localparam logic [3:0] RW_CHARS = 4'h8;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_X = 8'h58;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_A10 = 8'h37;
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam logic [7:0] CH_NAK = 8'h15;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] ERR_CMD = 8'h00;
    localparam logic [7:0] ERR_PARAM = 8'h02;
    localparam logic [15:0] TXT_MODE = 16'h4d44;
    localparam logic [23:0] TXT_TOR = 24'h544f52;
    localparam logic [15:0] TXT_OK = 16'h6f6b;
    typedef enum logic [1:0] {CYC_SERIAL, CYC_BLOCK, CYC_WRITE} cyc_e;
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic [3:0] op;
    } cmd_s;
    typedef struct packed {
        cyc_e kind;
        logic [7:0] block;
        logic [31:0] wdata;
    } cyc_req_s;
    typedef struct packed {
        logic ok;
        logic [39:0] data;
    } cyc_res_s;
    typedef struct packed {
        logic [4:0] len;
        logic [127:0] txt;
    } line_s;
endpackage : rdr_pkg

// ### rtl/rdr_trigger_seq.sv
// Command sequencer of the transponder reader with APB register access
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
module rdr_trigger_seq #(
    parameter int P_TB_CYC = rdr_pkg::TB_CYC
) (
    input wire logic I_SYS_CLK, // 40 MHz clock
    input wire logic I_RESET, // sync reset, high
    input wire logic I_PSEL, // APB select
    input wire logic I_PENABLE, // APB enable
    input wire logic I_PWRITE, // APB write
    input wire logic [7:0] I_PADDR, // APB byte address
    input wire logic [31:0] I_PWDATA, // APB write data
    output logic [31:0] O_PRDATA, // APB read data
    output logic O_PREADY, // APB ready
    output logic O_PSLVERR, // APB error
    output logic O_EXCITER_ON, // antenna exciter gate
    output logic O_CYC_START, // start one reading cycle
    output rdr_pkg::cyc_req_s O_CYC_REQ, // cycle kind and block
    input wire logic I_CYC_DONE, // cycle finished pulse
    input wire rdr_pkg::cyc_res_s I_CYC_RES, // cycle result
    input wire logic I_TAG_RW, // read/write tag type
    input wire logic I_TAG_2K, // 2 kbit tag type
    output logic O_TX_VALID, // answer char valid
    output logic [7:0] O_TX_DATA, // answer char
    input wire logic I_TX_READY, // answer char taken
    output logic O_SUCCESS_LAMP, // success lamp
    output logic O_NO_TAG_RESULT_LAMP // no-read lamp
);
    typedef enum logic [1:0] {ST_IDLE, ST_CYC, ST_SEND} st_e;
    localparam int TBW = $clog2(P_TB_CYC);

    function automatic rdr_pkg::line_s push(input rdr_pkg::line_s l,
                                            input logic [7:0] c);
        rdr_pkg::line_s r;
        r = l;
        r.txt[{l.len[3:0], 3'b000} +: 8] = c;
        r.len = l.len + 5'd1;
        return r;
    endfunction : push

    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? rdr_pkg::CH_0 + {4'h0, n}
                          : rdr_pkg::CH_A10 + {4'h0, n};
    endfunction : hexc

    // Hex text or X code of n characters, then CR
    function automatic rdr_pkg::line_s text_line(input logic [39:0] v,
            input logic [3:0] n, input logic bad);
        rdr_pkg::line_s r;
        logic [39:0] s;
        r = '0;
        s = v;
        for (int i = 0; i < 10; i++) begin
            if (i[3:0] < n) begin
                s = v >> {n - 4'd1 - i[3:0], 2'b00};
                r = push(r, bad ? rdr_pkg::CH_X : hexc(s[3:0]));
            end
        end
        return push(r, rdr_pkg::CH_CR);
    endfunction : text_line

    function automatic rdr_pkg::line_s dec_push(input rdr_pkg::line_s l,
                                                input logic [7:0] v);
        rdr_pkg::line_s r;
        r = l;
        if (v >= 8'd100)
            r = push(r, rdr_pkg::CH_0 + v / 8'd100);
        if (v >= 8'd10)
            r = push(r, rdr_pkg::CH_0 + (v / 8'd10) % 8'd10);
        return push(r, rdr_pkg::CH_0 + v % 8'd10);
    endfunction : dec_push

    function automatic rdr_pkg::line_s nak_line(input logic [7:0] code);
        rdr_pkg::line_s r;
        r = push('0, rdr_pkg::CH_NAK);
        r = push(r, rdr_pkg::CH_HASH);
        r = dec_push(push(r, rdr_pkg::CH_0), code);
        return push(r, rdr_pkg::CH_CR);
    endfunction : nak_line

    function automatic logic blk_ok(input logic [7:0] b, input logic k2);
        return k2 ? (b >= rdr_pkg::BLK2K_LO && b <= rdr_pkg::BLK2K_HI)
                  : (b >= rdr_pkg::BLK1K_LO && b <= rdr_pkg::BLK1K_HI);
    endfunction : blk_ok

    st_e state_q;
    rdr_pkg::cmd_s cmd_q;
    rdr_pkg::cyc_req_s req_q;
    rdr_pkg::line_s line_q;
    logic pend_q;
    logic [31:0] wdata_q;
    logic [1:0] mode_q;
    logic [7:0] tor_q;
    logic [1:0] smode_q;
    logic [7:0] stor_q;
    logic exc_q;
    logic start_q;
    logic gt_q;
    logic more_q;
    logic [7:0] last_q;
    logic [TBW-1:0] tb_q;
    logic [8:0] units_q;
    logic [31:0] prdata_q;
    logic succ_q;
    logic nord_q;
    logic [31:0] rd_d;
    logic map_ok;
    logic access;
    logic wr_cmd;
    logic take;
    logic [15:0] val16;
    logic [7:0] last_blk;
    logic [8:0] limit;
    logic win_exp;
    logic tor_bad;
    logic mode_bad;
    logic ld_no_tag_result_gt;

    // APB slave: read data latched in setup, always ready
    assign access = I_PSEL & I_PENABLE;
    assign wr_cmd = access & I_PWRITE & (I_PADDR == rdr_pkg::A_CMD) & ~pend_q;
    assign O_PREADY = 1'b1;
    assign O_PRDATA = prdata_q;
    assign O_PSLVERR = access & (~map_ok | (I_PWRITE & ((I_PADDR ==
        rdr_pkg::A_STATUS) | (I_PADDR == rdr_pkg::A_SAVED) |
        ((I_PADDR == rdr_pkg::A_CMD) & pend_q))));

    always_comb begin
        rd_d = '0;
        map_ok = 1'b1;
        if (I_PADDR == rdr_pkg::A_CMD) begin
            rd_d = {12'h000, cmd_q};
        end else if (I_PADDR == rdr_pkg::A_WDATA) begin
            rd_d = wdata_q;
        end else if (I_PADDR == rdr_pkg::A_STATUS) begin
            rd_d = {7'h00, units_q, state_q, pend_q, nord_q, succ_q, exc_q,
                    mode_q, tor_q};
        end else if (I_PADDR == rdr_pkg::A_SAVED) begin
            rd_d = {22'h000000, smode_q, stor_q};
        end else begin
            map_ok = 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            prdata_q <= '0;
            wdata_q <= '0;
        end else begin
            if (I_PSEL & ~I_PENABLE)
                prdata_q <= rd_d;
            if (access & I_PWRITE & (I_PADDR == rdr_pkg::A_WDATA))
                wdata_q <= I_PWDATA;
        end
    end

    // One command held at a time; a second write is refused
    assign take = (state_q == ST_IDLE) & pend_q;
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            pend_q <= 1'b0;
            cmd_q <= '0;
        end else if (wr_cmd) begin
            pend_q <= 1'b1;
            cmd_q <= I_PWDATA[19:0];
        end else if (take) begin
            pend_q <= 1'b0;
        end
    end

    assign val16 = {cmd_q.hi, cmd_q.lo};
    assign tor_bad = val16 > {8'h00, rdr_pkg::TOR_TOP};
    assign mode_bad = (val16 != {14'h0, rdr_pkg::MODE_CONT}) &&
                      (val16 != {14'h0, rdr_pkg::MODE_TRIG});
    assign last_blk = (cmd_q.hi == 8'h00) ? cmd_q.lo : cmd_q.hi;

    // Parameter storage
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            mode_q <= rdr_pkg::MODE_RST;
            tor_q <= rdr_pkg::TOR_RST;
            smode_q <= rdr_pkg::MODE_RST;
            stor_q <= rdr_pkg::TOR_RST;
        end else if (take) begin
            if (cmd_q.op == rdr_pkg::OP_SET_TOR && !tor_bad)
                tor_q <= cmd_q.lo;
            if (cmd_q.op == rdr_pkg::OP_SET_MODE && !mode_bad)
                mode_q <= cmd_q.lo[1:0];
            if (cmd_q.op == rdr_pkg::OP_PERSIST) begin
                smode_q <= mode_q;
                stor_q <= tor_q;
            end
        end
    end

    // Gating window: units of the fixed time base since trigger
    assign limit = (tor_q == rdr_pkg::TOR_TOP) ? rdr_pkg::TOR_FULL
                                               : {1'b0, tor_q};
    assign win_exp = units_q >= limit;
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET || take) begin
            tb_q <= '0;
            units_q <= '0;
        end else if (state_q == ST_CYC && gt_q && !win_exp) begin
            if (tb_q == TBW'(P_TB_CYC - 1)) begin
                tb_q <= '0;
                units_q <= units_q + 9'd1;
            end else begin
                tb_q <= tb_q + 1'b1;
            end
        end
    end

    // Lamps follow the last read or write result
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            succ_q <= 1'b0;
            nord_q <= 1'b0;
        end else if (state_q == ST_CYC && I_CYC_DONE) begin
            if (I_CYC_RES.ok || !gt_q || win_exp || tor_q == 8'h00) begin
                succ_q <= I_CYC_RES.ok;
                nord_q <= ~I_CYC_RES.ok;
            end
        end
    end

    assign ld_no_tag_result_gt = state_q == ST_CYC && I_CYC_DONE && gt_q &&
                          !I_CYC_RES.ok && (win_exp || tor_q == 8'h00);

    // Main sequencer
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            state_q <= ST_IDLE;
            exc_q <= 1'b0;
            start_q <= 1'b0;
            req_q <= '0;
            gt_q <= 1'b0;
            more_q <= 1'b0;
            last_q <= '0;
            line_q <= '0;
        end else begin
            start_q <= 1'b0;
            case (state_q)
            ST_IDLE: begin
                exc_q <= (mode_q == rdr_pkg::MODE_CONT);
                if (pend_q) begin
                    state_q <= ST_SEND;
                    more_q <= 1'b0;
                    gt_q <= 1'b0;
                    case (cmd_q.op)
                    rdr_pkg::OP_SET_TOR: begin
                        line_q <= tor_bad ? nak_line(rdr_pkg::ERR_PARAM)
                            : push(dec_push('0, cmd_q.lo),
                                   rdr_pkg::CH_CR);
                    end
                    rdr_pkg::OP_SET_MODE: begin
                        line_q <= mode_bad ? nak_line(rdr_pkg::ERR_PARAM)
                            : push(dec_push('0, cmd_q.lo),
                                   rdr_pkg::CH_CR);
                    end
                    rdr_pkg::OP_SHOW: begin
                        line_q <= push(dec_push(push(push(push(push(push(
                            dec_push(push(push(push('0, rdr_pkg::TXT_MODE
                            [15:8]), rdr_pkg::TXT_MODE[7:0]),
                            rdr_pkg::CH_SP), {6'h00, mode_q}),
                            rdr_pkg::CH_CR), rdr_pkg::TXT_TOR[23:16]),
                            rdr_pkg::TXT_TOR[15:8]), rdr_pkg::TXT_TOR[7:0]),
                            rdr_pkg::CH_SP), tor_q),
                            rdr_pkg::CH_CR);
                    end
                    rdr_pkg::OP_PERSIST: begin
                        line_q <= push(push(push('0, rdr_pkg::TXT_OK[15:8]),
                            rdr_pkg::TXT_OK[7:0]),
                            rdr_pkg::CH_CR);
                    end
                    rdr_pkg::OP_GET_TAG, rdr_pkg::OP_SEL_READ,
                    rdr_pkg::OP_WRITE: begin
                        if (mode_q != rdr_pkg::MODE_TRIG) begin
                            line_q <= nak_line(rdr_pkg::ERR_CMD);
                        end else if (cmd_q.op != rdr_pkg::OP_GET_TAG &&
                                (!blk_ok(cmd_q.lo, I_TAG_2K) ||
                                 !blk_ok(last_blk, I_TAG_2K) ||
                                 last_blk < cmd_q.lo)) begin
                            line_q <= nak_line(rdr_pkg::ERR_PARAM);
                        end else begin
                            state_q <= ST_CYC;
                            exc_q <= 1'b1;
                            start_q <= 1'b1;
                            gt_q <= cmd_q.op == rdr_pkg::OP_GET_TAG;
                            last_q <= last_blk;
                            req_q.wdata <= wdata_q;
                            req_q.block <= cmd_q.lo;
                            if (cmd_q.op == rdr_pkg::OP_GET_TAG) begin
                                req_q.kind <= rdr_pkg::CYC_SERIAL;
                                req_q.block <= I_TAG_2K ? rdr_pkg::SER_BLK_2K
                                                        : rdr_pkg::SER_BLK_1K;
                            end else if (cmd_q.op == rdr_pkg::OP_SEL_READ) begin
                                req_q.kind <= rdr_pkg::CYC_BLOCK;
                            end else begin
                                req_q.kind <= rdr_pkg::CYC_WRITE;
                            end
                        end
                    end
                    default: line_q <= nak_line(rdr_pkg::ERR_CMD);
                    endcase
                end else if (mode_q == rdr_pkg::MODE_CONT) begin
                    state_q <= ST_CYC;
                    start_q <= 1'b1;
                    gt_q <= 1'b0;
                    more_q <= 1'b0;
                    req_q.kind <= rdr_pkg::CYC_SERIAL;
                    req_q.block <= I_TAG_2K ? rdr_pkg::SER_BLK_2K
                                            : rdr_pkg::SER_BLK_1K;
                end
            end
            ST_CYC: begin
                if (I_CYC_DONE) begin
                    if (!I_CYC_RES.ok && gt_q && !win_exp &&
                            tor_q != 8'h00) begin
                        start_q <= 1'b1;
                    end else begin
                        state_q <= ST_SEND;
                        more_q <= req_q.kind == rdr_pkg::CYC_BLOCK &&
                                  req_q.block < last_q;
                        if (mode_q == rdr_pkg::MODE_TRIG &&
                                !(req_q.kind == rdr_pkg::CYC_BLOCK &&
                                  req_q.block < last_q))
                            exc_q <= 1'b0;
                        if (req_q.kind == rdr_pkg::CYC_WRITE) begin
                            line_q <= push(push('0, I_CYC_RES.ok ?
                                rdr_pkg::CH_ACK : rdr_pkg::CH_NAK),
                                rdr_pkg::CH_CR);
                        end else if (req_q.kind == rdr_pkg::CYC_BLOCK) begin
                            line_q <= text_line({8'h00, I_CYC_RES.data[31:0]},
                                rdr_pkg::RW_CHARS, !I_CYC_RES.ok);
                        end else begin
                            line_q <= text_line(I_CYC_RES.data, I_TAG_RW ?
                                rdr_pkg::RW_CHARS : rdr_pkg::RO_CHARS,
                                !I_CYC_RES.ok);
                        end
                    end
                end
            end
            ST_SEND: begin
                if (I_TX_READY) begin
                    line_q.txt <= line_q.txt >> 8;
                    line_q.len <= line_q.len - 5'd1;
                    if (line_q.len == 5'd1) begin
                        if (more_q) begin
                            state_q <= ST_CYC;
                            start_q <= 1'b1;
                            req_q.block <= req_q.block + 8'd1;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
            end
            default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign O_EXCITER_ON = exc_q;
    assign O_CYC_START = start_q;
    assign O_CYC_REQ = req_q;
    assign O_TX_VALID = state_q == ST_SEND;
    assign O_TX_DATA = line_q.txt[7:0];
    assign O_SUCCESS_LAMP = succ_q;
    assign O_NO_TAG_RESULT_LAMP = nord_q;

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);

    sequence idle_trig;
        state_q == ST_IDLE && mode_q == rdr_pkg::MODE_TRIG;
    endsequence

    exciter_idle_off_a: assert property (
        idle_trig ##1 idle_trig |-> !exc_q)
        else $error("exciter on while idle in triggered mode");
    start_pulse_a: assert property (
        O_CYC_START |=> !O_CYC_START)
        else $error("cycle start longer than one cycle");
    no_tag_result_window_a: assert property (
        state_q == ST_CYC && gt_q && !win_exp && tor_q != 8'h00 &&
        !(I_CYC_DONE && I_CYC_RES.ok) |=> !O_TX_VALID)
        else $error("no-read sent while window running");
    no_tag_result_result_a: assert property (
        ld_no_tag_result_gt |=> O_NO_TAG_RESULT_LAMP && O_TX_DATA == rdr_pkg::CH_X)
        else $error("no-read result missing at window end");
    success_off_a: assert property (
        state_q == ST_CYC && I_CYC_DONE && I_CYC_RES.ok &&
        mode_q == rdr_pkg::MODE_TRIG && req_q.kind != rdr_pkg::CYC_BLOCK
        |=> !exc_q && state_q == ST_SEND)
        else $error("exciter not off after success");
    units_cap_a: assert property (
        units_q <= limit)
        else $error("window counter beyond cap");
    line_end_cr_a: assert property (
        O_TX_VALID && line_q.len == 5'd1 |-> O_TX_DATA == rdr_pkg::CH_CR)
        else $error("answer does not end in CR");
    persist_copy_a: assert property (
        take && cmd_q.op == rdr_pkg::OP_PERSIST
        |=> stor_q == $past(tor_q) && smode_q == $past(mode_q))
        else $error("persist did not copy parameters");
    tor_reject_a: assert property (
        take && cmd_q.op == rdr_pkg::OP_SET_TOR && tor_bad |=> $stable(tor_q))
        else $error("out of range timeout accepted");
    zero_once_a: assert property (
        state_q == ST_CYC && I_CYC_DONE && tor_q == 8'h00 && gt_q
        |=> state_q == ST_SEND)
        else $error("more than one cycle with zero timeout");
endmodule : rdr_trigger_seq
`default_nettype wire

// ### tb/rdr_front_model.sv
// Reader front end model that answers reading cycle starts
`timescale 1ns/100ps
`default_nettype none
module rdr_front_model (
    input wire logic i_clk, // clock
    input wire logic i_rst, // sync reset
    input wire logic i_start, // cycle start pulse
    input wire logic i_exciter, // exciter gate
    input wire logic [7:0] i_fails, // failed cycles before a tag is seen
    input wire logic [39:0] i_data, // tag data
    output logic o_done, // cycle done pulse
    output rdr_pkg::cyc_res_s o_res // cycle result
);
    logic [3:0] wait_q;
    logic [7:0] seen_q;
    always_ff @(posedge i_clk) begin
        o_done <= 1'b0;
        o_res <= {1'b0, ~i_data}; // Junk outside done
        if (i_rst || !i_exciter) begin
            wait_q <= 4'h0;
            seen_q <= 8'h00;
        end else if (i_start) begin
            wait_q <= 4'h5;
        end else if (wait_q == 4'h1) begin
            wait_q <= 4'h0;
            o_done <= 1'b1;
            o_res <= {seen_q >= i_fails, i_data};
            seen_q <= seen_q + 8'h01;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end
    end
endmodule : rdr_front_model
`default_nettype wire

// ### tb/rdr_trigger_seq_test.sv
// Self-checking bench of the reader trigger sequencer
`timescale 1ns/100ps
`default_nettype none
module rdr_trigger_seq_test;
    localparam int TBC = 20;
    logic clk, rst, psel, pen, pwr, done, rw, k2, rdy, rerr, exc, start;
    logic txv, lok, lno, pready, slverr;
    logic [7:0] addr, fails, txd;
    logic [31:0] wdat, rdat, prdata;
    logic [39:0] tag;
    rdr_pkg::cyc_req_s req;
    rdr_pkg::cyc_res_s res;
    int err_count, samples_checked, starts, gap;
    rdr_trigger_seq #(.P_TB_CYC(TBC)) u_dut (.I_SYS_CLK(clk), .I_RESET(rst),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(addr),
        .I_PWDATA(wdat), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(slverr), .O_EXCITER_ON(exc), .O_CYC_START(start),
        .O_CYC_REQ(req), .I_CYC_DONE(done), .I_CYC_RES(res), .I_TAG_RW(rw),
        .I_TAG_2K(k2), .O_TX_VALID(txv), .O_TX_DATA(txd), .I_TX_READY(rdy),
        .O_SUCCESS_LAMP(lok), .O_NO_TAG_RESULT_LAMP(lno));
    rdr_front_model u_front (.i_clk(clk), .i_rst(rst), .i_start(start),
        .i_exciter(exc), .i_fails(fails), .i_data(tag), .o_done(done),
        .o_res(res));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (start === 1'b1) starts++;
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (e !== g) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, addr, wdat} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {rdat, rerr} = {prdata, slverr};
        {psel, pen} <= 2'b00;
    endtask : apb
    task automatic send(input logic [3:0] op, input logic [15:0] v);
        apb(1'b1, rdr_pkg::A_CMD, {12'h000, v, op});
    endtask : send
    // Each negedge with valid shows one char, taken at the next edge
    task automatic rx(input string s);
        int n;
        for (int i = 0; i < s.len(); i++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (txv !== 1'b1);
            if (i == 0) gap = n;
            chk("tx char", {24'h0, s[i]}, {24'h0, txd});
            @(posedge clk);
        end
    endtask : rx
    initial begin
        {rst, psel, pen, pwr, addr, wdat, rdy, k2, rw} = {4'h8, 40'h0, 3'h4};
        {fails, tag, starts, gap} = {8'hff, 40'h00c0ffee5a, 64'h0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk("idle exciter", 32'h0, exc);
        apb(1'b0, rdr_pkg::A_STATUS, 32'h0);
        chk("status", 32'h20a, rdat & 32'h1fff);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, rerr);
        apb(1'b1, rdr_pkg::A_STATUS, 32'h0);
        chk("ro write", 32'h1, rerr);
        send(rdr_pkg::OP_SET_TOR, 16'h012c);
        rx("\025#02\r");
        send(rdr_pkg::OP_SET_MODE, 16'h0001);
        rx("\025#02\r");
        send(4'h7, 16'h0000);
        rx("\025#00\r");
        send(rdr_pkg::OP_SET_TOR, 16'h0000);
        rx("0\r");
        starts = 0;
        send(rdr_pkg::OP_GET_TAG, 16'h0);
        rx("XXXXXXXXXX\r");
        chk("one cycle", 32'h1, starts);
        chk("no_tag_result lamp", 32'h1, {lok, lno});
        send(rdr_pkg::OP_SET_TOR, 16'h0001);
        rx("1\r");
        starts = 0;
        send(rdr_pkg::OP_GET_TAG, 16'h0);
        rx("XXXXXXXXXX\r");
        chk("quiet window", 32'h1, gap >= TBC);
        chk("retries", 32'h1, starts > 1 && starts <= 5);
        send(rdr_pkg::OP_SET_TOR, 16'h0002);
        rx("2\r");
        {fails, rw, starts} <= {8'h02, 1'b0, 32'h0};
        send(rdr_pkg::OP_GET_TAG, 16'h0);
        rx("00C0FFEE5A\r");
        chk("cycles", 32'h3, starts);
        chk("ok lamp", 32'h2, {lok, lno});
        chk("exciter off", 32'h0, exc);
        rw <= 1'b1;
        send(rdr_pkg::OP_GET_TAG, 16'h0);
        rx("C0FFEE5A\r");
        chk("serial blk", 32'h20, req.block);
        fails <= 8'h01;
        send(rdr_pkg::OP_SEL_READ, 16'h0403);
        rx("XXXXXXXX\rC0FFEE5A\r");
        chk("last blk", 32'h4, req.block);
        apb(1'b1, rdr_pkg::A_WDATA, 32'h12345678);
        send(rdr_pkg::OP_WRITE, 16'h0005);
        rx("\025\r");
        chk("write data", 32'h12345678, req.wdata);
        send(rdr_pkg::OP_SEL_READ, 16'h0002);
        rx("\025#02\r");
        k2 <= 1'b1;
        send(rdr_pkg::OP_SEL_READ, 16'h000f);
        rx("\025#02\r");
        send(rdr_pkg::OP_GET_TAG, 16'h0);
        rx("C0FFEE5A\r");
        chk("serial blk 2k", 32'h1, req.block);
        send(rdr_pkg::OP_SHOW, 16'h0);
        rx("MD 2\rTOR 2\r");
        send(rdr_pkg::OP_PERSIST, 16'h0);
        rx("ok\r");
        apb(1'b0, rdr_pkg::A_SAVED, 32'h0);
        chk("saved", 32'h202, rdat);
        send(rdr_pkg::OP_SET_MODE, 16'h0000);
        rx("0\r");
        repeat (20) @(posedge clk);
        chk("cont exciter", 32'h1, exc);
        chk("cont kind", rdr_pkg::CYC_SERIAL, req.kind);
        chk("cont blk", 32'h1, req.block);
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule : rdr_trigger_seq_test
`default_nettype wire
